// >>> usst_core.sv
// usst_core: sync/async serial transceiver behind an Avalon-MM slave
// assumes line clocks and serial inputs are synchronous to clk_i
`timescale 1ns/1ns
module usst_core #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              cts_n_i,
	input  wire logic              tx_bit_clock_i,
	input  wire logic              rx_bit_clock_i,
	input  wire logic              rx_i,
	input  wire logic              ext_sync_in_i,
	output logic                   tx_o,
	output logic                   tx_ready_line_o,
	output logic                   tx_drained_o,
	output logic                   rx_char_avail_o,
	output logic                   sync_found_out_o
);
	if (ADDR_W < 8) begin : g_chk
		$error("ADDR_W must hold the register byte addresses");
	end

	usst_pkg::usst_state_t s_q;
	usst_pkg::usst_state_t s_d;
	logic       req;
	logic       acc;
	logic       hit_data;
	logic       hit_ctrl;
	logic       data_wr;
	logic       ctrl_wr;
	logic       cmd_wr;
	logic [7:0] wd;
	logic [7:0] status;
	logic       txc_rise;
	logic       rxc_rise;
	logic       is_sync;
	logic       ext_mode;
	logic [3:0] len;
	logic [3:0] plen;
	logic [5:0] fm1;
	logic [5:0] halfm1;
	logic       tx_tick;
	logic       tx_load;
	logic       rx_deliver;
	logic       stop_low;
	logic       do_rxdis;
	logic       do_hunt;
	logic       do_rst;

	////////////////////////////////////////////////////////////////////////
	assign req      = avs_read_i | avs_write_i;
	assign acc      = req & s_q.ack;
	assign hit_data = avs_address_i == ADDR_W'(usst_pkg::ADDR_DATA);
	assign hit_ctrl = avs_address_i == ADDR_W'(usst_pkg::ADDR_CTRL);
	assign wd       = avs_writedata_i[7:0];
	assign data_wr  = acc & avs_write_i & avs_byteenable_i[0] & hit_data;
	assign ctrl_wr  = acc & avs_write_i & avs_byteenable_i[0] & hit_ctrl;
	assign cmd_wr   = ctrl_wr & (s_q.init == usst_pkg::INIT_CMD);
	// one wait cycle per access keeps read data a flop output
	assign avs_waitrequest_o = req & ~s_q.ack;
	assign avs_readdata_o    = s_q.rdata;

	assign txc_rise = tx_bit_clock_i & ~s_q.txc_prev;
	assign rxc_rise = rx_bit_clock_i & ~s_q.rxc_prev;
	assign is_sync  = s_q.mode[usst_pkg::MODE_BAUD_HI:usst_pkg::MODE_BAUD_LO]
		== usst_pkg::BAUD_SYNC;
	assign ext_mode = s_q.mode[usst_pkg::MODE_EXTSYNC];
	assign len      = usst_pkg::char_len(s_q.mode);
	assign plen     = len + {3'h0, s_q.mode[usst_pkg::MODE_PEN]};
	assign fm1      = 6'(usst_pkg::factor(s_q.mode) - 7'h01);
	assign halfm1   = 6'((usst_pkg::factor(s_q.mode) >> 1) - 7'h01);

	assign status = {1'b0, s_q.found, s_q.fe, s_q.oe, s_q.pe,
		tx_drained_o, s_q.avail, ~s_q.hold_v};
	assign tx_ready_line_o = ~s_q.hold_v & ~cts_n_i & s_q.cmd[usst_pkg::CMD_TXEN]
		& (s_q.init == usst_pkg::INIT_CMD);
	assign tx_drained_o     = ~s_q.hold_v & ((s_q.tx_left == 4'h0) | s_q.tx_fill);
	assign rx_char_avail_o  = s_q.avail;
	assign sync_found_out_o = s_q.found;
	assign tx_o             = s_q.txd;

	function automatic logic [1:0] ext_next(input logic [1:0] c);
		return (c == usst_pkg::EXT_SYNC_EDGES) ? c : c + 2'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [15:0] fr;
		logic [15:0] hist;
		logic [7:0]  ch;
		logic        perr;
		logic        found_now;
		logic        samp;
		logic        txen;
		logic        rxen;
		fr = 16'h0;
		hist = 16'h0;
		ch = 8'h0;
		perr = 1'b0;
		found_now = 1'b0;
		samp = 1'b0;
		txen = 1'b0;
		rxen = 1'b0;
		s_d = s_q;
		tx_tick = 1'b0;
		tx_load = 1'b0;
		rx_deliver = 1'b0;
		stop_low = 1'b0;
		do_rxdis = 1'b0;
		do_hunt = 1'b0;
		do_rst = 1'b0;
		s_d.txc_prev = tx_bit_clock_i;
		s_d.rxc_prev = rx_bit_clock_i;

		// bus slave
		s_d.ack = req & ~s_q.ack;
		if (req & ~s_q.ack) begin
			if (hit_data) begin
				s_d.rdata = {24'h0, s_q.rx_buf};
			end else if (hit_ctrl) begin
				s_d.rdata = {24'h0, status};
			end else begin
				s_d.rdata = 32'h0;
			end
		end
		if (acc & avs_read_i & hit_data) begin
			s_d.avail = 1'b0;
		end
		if (acc & avs_read_i & hit_ctrl) begin
			s_d.found = 1'b0;
		end
		if (data_wr) begin
			s_d.hold   = wd;
			s_d.hold_v = 1'b1;
		end
		if (ctrl_wr) begin
			case (s_q.init)
				usst_pkg::INIT_MODE: begin
					s_d.mode = wd;
					s_d.init = (wd[usst_pkg::MODE_BAUD_HI:usst_pkg::MODE_BAUD_LO]
						== usst_pkg::BAUD_SYNC) ? usst_pkg::INIT_SYNC1
						: usst_pkg::INIT_CMD;
				end
				usst_pkg::INIT_SYNC1: begin
					s_d.sync1 = wd;
					s_d.init  = s_q.mode[usst_pkg::MODE_SINGLE] ? usst_pkg::INIT_CMD
						: usst_pkg::INIT_SYNC2;
				end
				usst_pkg::INIT_SYNC2: begin
					s_d.sync2 = wd;
					s_d.init  = usst_pkg::INIT_CMD;
				end
				usst_pkg::INIT_CMD: begin
					if (wd[usst_pkg::CMD_SWRST]) begin
						do_rst = 1'b1;
					end else begin
						s_d.cmd  = wd;
						do_rxdis = ~wd[usst_pkg::CMD_RXEN];
						do_hunt  = wd[usst_pkg::CMD_HUNT] & is_sync;
						if (wd[usst_pkg::CMD_ERRCLR]) begin
							s_d.pe = 1'b0;
							s_d.oe = 1'b0;
							s_d.fe = 1'b0;
						end
					end
				end
				default: s_d.init = usst_pkg::INIT_MODE;
			endcase
		end
		txen = s_d.cmd[usst_pkg::CMD_TXEN];
		rxen = s_d.cmd[usst_pkg::CMD_RXEN];

		////////////////////////////////////////////////////////////////////
		// transmitter: a running frame completes unless a software reset drops it
		if (txc_rise) begin
			if (s_q.tx_div == fm1) begin
				s_d.tx_div = 6'h0;
				tx_tick    = 1'b1;
			end else begin
				s_d.tx_div = s_q.tx_div + 6'h1;
			end
		end
		if (tx_tick) begin
			if (s_q.tx_left != 4'h0) begin
				s_d.line    = s_q.tx_sh[0];
				s_d.tx_sh   = {1'b1, s_q.tx_sh[11:1]};
				s_d.tx_left = s_q.tx_left - 4'h1;
			end else if (s_d.hold_v & txen & ~cts_n_i) begin
				fr = usst_pkg::frame(s_d.hold, s_q.mode, ~is_sync);
				s_d.hold_v     = 1'b0;
				s_d.tx_started = 1'b1;
				s_d.tx_fill    = 1'b0;
				tx_load        = 1'b1;
			end else if (is_sync & s_q.tx_started & txen) begin
				fr = usst_pkg::frame(s_q.tx_sel ? s_q.sync2 : s_q.sync1,
					s_q.mode, 1'b0);
				s_d.tx_fill = 1'b1;
				s_d.tx_sel  = ~s_q.tx_sel & ~s_q.mode[usst_pkg::MODE_SINGLE];
			end else begin
				s_d.tx_fill = 1'b0;
				s_d.line    = usst_pkg::LINE_MARK;
			end
			if (fr[15:12] != 4'h0) begin
				s_d.line    = fr[0];
				s_d.tx_sh   = {1'b1, fr[11:1]};
				s_d.tx_left = fr[15:12] - 4'h1;
			end
		end
		s_d.txd = s_d.cmd[usst_pkg::CMD_BRK] ? 1'b0 : s_d.line;

		////////////////////////////////////////////////////////////////////
		// receiver
		if (!is_sync) begin
			if (!rxen) begin
				s_d.rx_st = usst_pkg::RX_WAIT_HIGH;
			end else if (rxc_rise) begin
				samp = s_q.rx_div == fm1;
				s_d.rx_div = samp ? 6'h0 : s_q.rx_div + 6'h1;
				case (s_q.rx_st)
					usst_pkg::RX_WAIT_HIGH: begin
						if (rx_i) begin
							s_d.rx_st = usst_pkg::RX_WAIT_LOW;
						end
					end
					usst_pkg::RX_WAIT_LOW: begin
						s_d.rx_div  = 6'h0;
						s_d.rx_bits = 4'h0;
						if (!rx_i) begin
							s_d.rx_st = (fm1 == 6'h0) ? usst_pkg::RX_DATA
								: usst_pkg::RX_START;
						end
					end
					usst_pkg::RX_START: begin
						// centre check filters glitches on the line
						if (s_q.rx_div == halfm1) begin
							s_d.rx_div = 6'h0;
							s_d.rx_st  = rx_i ? usst_pkg::RX_WAIT_LOW
								: usst_pkg::RX_DATA;
						end
					end
					usst_pkg::RX_DATA: begin
						if (samp) begin
							s_d.rx_data[s_q.rx_bits[2:0]] = rx_i;
							s_d.rx_bits = s_q.rx_bits + 4'h1;
							if (s_q.rx_bits == len - 4'h1) begin
								s_d.rx_st = s_q.mode[usst_pkg::MODE_PEN]
									? usst_pkg::RX_PAR : usst_pkg::RX_STOP;
							end
						end
					end
					usst_pkg::RX_PAR: begin
						if (samp) begin
							s_d.rx_par = rx_i;
							s_d.rx_st  = usst_pkg::RX_STOP;
						end
					end
					usst_pkg::RX_STOP: begin
						if (samp) begin
							ch = s_q.rx_data & usst_pkg::len_mask(len);
							perr = s_q.mode[usst_pkg::MODE_PEN] & (s_q.rx_par !=
								usst_pkg::parity(ch, len, s_q.mode[usst_pkg::MODE_PEVEN]));
							stop_low   = ~rx_i;
							rx_deliver = 1'b1;
							s_d.rx_st  = usst_pkg::RX_WAIT_HIGH;
						end
					end
					default: s_d.rx_st = usst_pkg::RX_WAIT_HIGH;
				endcase
			end
		end else if (rxc_rise) begin
			hist = {rx_i, s_q.hist[15:1]};
			s_d.hist = hist;
			if (s_q.hunt) begin
				if (ext_mode) begin
					s_d.ext_cnt = ext_sync_in_i ? ext_next(s_q.ext_cnt) : 2'h0;
					found_now = ext_sync_in_i
						& (s_q.ext_cnt == usst_pkg::EXT_SYNC_EDGES - 2'h1);
				end else if (s_q.pend) begin
					found_now = 1'b1;
				end else if (usst_pkg::extract(hist, len, 4'h0) ==
					((s_q.mode[usst_pkg::MODE_SINGLE] ? s_q.sync1 : s_q.sync2)
					& usst_pkg::len_mask(len)) && (s_q.mode[usst_pkg::MODE_SINGLE] ||
					usst_pkg::extract(hist, len, len) ==
					(s_q.sync1 & usst_pkg::len_mask(len)))) begin
					found_now = ~s_q.mode[usst_pkg::MODE_PEN];
					s_d.pend  = s_q.mode[usst_pkg::MODE_PEN];
				end
				if (found_now) begin
					s_d.found   = 1'b1;
					s_d.hunt    = 1'b0;
					s_d.pend    = 1'b0;
					s_d.rx_bits = 4'h0;
				end
			end else begin
				s_d.rx_bits = s_q.rx_bits + 4'h1;
				if (s_q.rx_bits == plen - 4'h1) begin
					s_d.rx_bits = 4'h0;
					ch = usst_pkg::extract(hist, len, {3'h0, s_q.mode[usst_pkg::MODE_PEN]});
					perr = s_q.mode[usst_pkg::MODE_PEN] & (hist[15] !=
						usst_pkg::parity(ch, len, s_q.mode[usst_pkg::MODE_PEVEN]));
					rx_deliver = 1'b1;
					if (!ext_mode && ch == (s_q.sync1 & usst_pkg::len_mask(len))) begin
						s_d.found = 1'b1;
					end
				end
			end
		end

		// flags: hardware sets win over read and error clear; disable, hunt and reset win over sets
		if (rx_deliver) begin
			s_d.rx_buf = ch;
			if (s_q.avail & rxen) begin
				s_d.oe = 1'b1;
			end
			if (rxen) begin
				s_d.avail = 1'b1;
			end
			if (perr) begin
				s_d.pe = 1'b1;
			end
			if (stop_low) begin
				s_d.fe = 1'b1;
			end
		end

		// disable and hunt discard the held character outright
		if (do_rxdis) begin
			s_d.avail = 1'b0;
			s_d.oe    = 1'b0;
		end
		if (do_hunt) begin
			s_d.avail   = 1'b0;
			s_d.found   = 1'b0;
			s_d.hunt    = 1'b1;
			s_d.pend    = 1'b0;
			s_d.ext_cnt = 2'h0;
		end
		if (do_rst) begin
			s_d.init  = usst_pkg::INIT_MODE;
			s_d.cmd   = 8'h00;
			s_d.hunt  = 1'b0;
			s_d.avail = 1'b0;
			s_d.pe    = 1'b0;
			s_d.oe    = 1'b0;
			s_d.fe    = 1'b0;
			s_d.found = 1'b0;
			s_d.tx_started = 1'b0;
			s_d.rx_st = usst_pkg::RX_WAIT_HIGH;
			// a frame in flight is dropped so the line marks at once
			s_d.line    = usst_pkg::LINE_MARK;
			s_d.tx_left = 4'h0;
			s_d.hold_v  = 1'b0;
			s_d.txd   = usst_pkg::LINE_MARK;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q      <= '0;
			s_q.line <= usst_pkg::LINE_MARK;
			s_q.txd  <= usst_pkg::LINE_MARK;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_bus_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus access not answered after one wait cycle");
	a_mode_to_sync: assert property (ctrl_wr && s_q.init == usst_pkg::INIT_MODE
		&& wd[1:0] == usst_pkg::BAUD_SYNC |=> s_q.init == usst_pkg::INIT_SYNC1)
		else $error("sync mode write did not await sync character");
	a_async_skip: assert property (ctrl_wr && s_q.init == usst_pkg::INIT_MODE
		&& wd[1:0] != usst_pkg::BAUD_SYNC |=> s_q.init == usst_pkg::INIT_CMD)
		else $error("async mode write did not reach command state");
	a_cmd_loaded: assert property (cmd_wr && !wd[usst_pkg::CMD_SWRST]
		|=> s_q.init == usst_pkg::INIT_CMD && s_q.cmd == $past(wd))
		else $error("command write not taken as command");
	a_wr_drops_ready: assert property (data_wr && !tx_tick
		|=> !tx_ready_line_o && !tx_drained_o)
		else $error("write left ready or drained high");
	a_break_low: assert property (s_q.cmd[usst_pkg::CMD_BRK]
		&& s_q.init == usst_pkg::INIT_CMD && !do_rst && !cmd_wr |=> !tx_o)
		else $error("break did not hold line low");
	a_mark_idle: assert property (!s_q.tx_started
		&& !s_q.cmd[usst_pkg::CMD_BRK] && !$past(s_q.cmd[usst_pkg::CMD_BRK]) |-> tx_o)
		else $error("line not marking before first character");
	a_disable_clears: assert property (cmd_wr && !wd[usst_pkg::CMD_RXEN]
		|=> !rx_char_avail_o && !s_q.oe)
		else $error("receive disable left ready or overrun");
	a_async_halt: assert property (!is_sync && !s_d.cmd[usst_pkg::CMD_RXEN]
		|=> s_q.rx_st == usst_pkg::RX_WAIT_HIGH)
		else $error("async receiver ran while disabled");
	a_overrun_set: assert property (rx_deliver && s_q.avail && !do_rst
		&& s_d.cmd[usst_pkg::CMD_RXEN] && !do_rxdis |=> s_q.oe)
		else $error("unread character did not raise overrun");
	a_frame_err: assert property (rx_deliver && stop_low && !do_rst |=> s_q.fe)
		else $error("low stop bit did not raise framing error");
	a_pe_sticky: assert property (s_q.pe && !do_rst
		&& !(cmd_wr && wd[usst_pkg::CMD_ERRCLR]) |=> s_q.pe)
		else $error("parity error lost without error clear");
	a_hunt_entry: assert property (do_hunt && !do_rst
		|=> s_q.hunt && !rx_char_avail_o && !sync_found_out_o)
		else $error("enter hunt did not restart the search");
	a_ext_found: assert property (is_sync && ext_mode && s_q.hunt && rxc_rise
		&& ext_sync_in_i && s_q.ext_cnt == 2'h1 && !do_hunt && !do_rst
		|=> sync_found_out_o && !s_q.hunt)
		else $error("external sync did not end hunt");

	c_tx_load: cover property (tx_load ##1 !tx_drained_o);
	c_rx_char: cover property (rx_deliver ##1 rx_char_avail_o);
	c_sync_found: cover property (s_q.hunt ##1 !s_q.hunt && sync_found_out_o);
	c_overrun: cover property (rx_deliver && s_q.avail);
endmodule

// >>> usst_pkg.sv
// usst_pkg: constants, types and helpers of the serial transceiver
// assumes one 10 MHz clock; line clocks arrive as sampled levels
// What this block does
// - txen off: finish current character, then mark
// - rxen off: async halts, sync clears ready/overrun
// - enter hunt searches sync at every bit
// - ready line needs free buffer, cts low, txen
// - status bit 0 means buffer writable only
// - drained high when nothing left to send
// - char ready cleared by read, disable, hunt
// - after reset first control write loads mode
// - sync mode takes one or two sync chars
// - later control writes are commands
// - async frames start/parity/stop; break drives low
// - async line idles high between characters
// - bits shift on tx clock /1 /16 /64
// - start bit needs high, low, low at centre (centre check at /16 and /64 only)
// - parity, overrun, framing errors never stop reception
// - sync tx marks first, then fills with sync
// - internal hunt compares each rx edge, bisync contiguous
// - sync found raised at last data/parity bit
// - internal sync compares sync at each character boundary after hunt
// - external sync high over one rx cycle
// - sync rx ignores txen; no parity in hunt
// - overrun on unread char; cleared by clear/disable
// - parity error sticky until error clear
package usst_pkg;
	localparam logic [7:0] IDX_DATA  = 8'h38;
	localparam logic [7:0] IDX_CTRL  = 8'h39;
	localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'b00};
	localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
	localparam int MODE_BAUD_LO = 0;
	localparam int MODE_BAUD_HI = 1;
	localparam int MODE_LEN_LO  = 2;
	localparam int MODE_LEN_HI  = 3;
	localparam int MODE_PEN     = 4;
	localparam int MODE_PEVEN   = 5;
	localparam int MODE_EXTSYNC = 6;
	localparam int MODE_STOP2   = 7;
	localparam int MODE_SINGLE  = 7;
	localparam logic [1:0] BAUD_SYNC = 2'h0;
	localparam logic [1:0] BAUD_X1   = 2'h1;
	localparam logic [1:0] BAUD_X16  = 2'h2;
	localparam logic [6:0] FACT_X1   = 7'h01;
	localparam logic [6:0] FACT_X16  = 7'h10;
	localparam logic [6:0] FACT_X64  = 7'h40;
	localparam logic [3:0] LEN_MIN   = 4'h5;
	localparam int CMD_TXEN   = 0;
	localparam int CMD_RXEN   = 2;
	localparam int CMD_BRK    = 3;
	localparam int CMD_ERRCLR = 4;
	localparam int CMD_SWRST  = 6;
	localparam int CMD_HUNT   = 7;
	localparam logic [1:0] EXT_SYNC_EDGES = 2'h2;
	localparam logic       LINE_MARK      = 1'b1;

	typedef enum logic [1:0] {
		INIT_MODE  = 2'b00,
		INIT_SYNC1 = 2'b01,
		INIT_SYNC2 = 2'b10,
		INIT_CMD   = 2'b11
	} usst_init_t;

	typedef enum logic [2:0] {
		RX_WAIT_HIGH = 3'b000,
		RX_WAIT_LOW  = 3'b001,
		RX_START     = 3'b010,
		RX_DATA      = 3'b011,
		RX_PAR       = 3'b100,
		RX_STOP      = 3'b101
	} usst_rx_t;

	typedef struct packed {
		usst_init_t  init;
		logic [7:0]  mode;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic [7:0]  cmd;
		logic        ack;
		logic [31:0] rdata;
		logic        txc_prev;
		logic        rxc_prev;
		logic        hold_v;
		logic [7:0]  hold;
		logic [11:0] tx_sh;
		logic [3:0]  tx_left;
		logic [5:0]  tx_div;
		logic        tx_started;
		logic        tx_fill;
		logic        tx_sel;
		logic        line;
		logic        txd;
		usst_rx_t    rx_st;
		logic [5:0]  rx_div;
		logic [3:0]  rx_bits;
		logic [7:0]  rx_data;
		logic        rx_par;
		logic [15:0] hist;
		logic        hunt;
		logic [1:0]  ext_cnt;
		logic        pend;
		logic [7:0]  rx_buf;
		logic        avail;
		logic        pe;
		logic        oe;
		logic        fe;
		logic        found;
	} usst_state_t;

	function automatic logic [3:0] char_len(input logic [7:0] m);
		return LEN_MIN + {2'b00, m[MODE_LEN_HI:MODE_LEN_LO]};
	endfunction

	function automatic logic [6:0] factor(input logic [7:0] m);
		case (m[MODE_BAUD_HI:MODE_BAUD_LO])
			BAUD_SYNC, BAUD_X1: return FACT_X1;
			BAUD_X16: return FACT_X16;
			default: return FACT_X64;
		endcase
	endfunction

	function automatic logic [7:0] len_mask(input logic [3:0] len);
		return 8'(8'hff >> (4'h8 - len));
	endfunction

	function automatic logic parity(input logic [7:0] d, input logic [3:0] len,
			input logic even);
		logic p;
		p = ^(d & len_mask(len));
		return even ? p : ~p;
	endfunction

	// bits lsb first in [11:0], bit count in [15:12]
	function automatic logic [15:0] frame(input logic [7:0] d, input logic [7:0] m,
			input logic is_async);
		logic [11:0] v;
		logic [3:0]  n;
		logic [3:0]  len;
		int          i;
		len = char_len(m);
		v = 12'hfff;
		n = 4'h0;
		if (is_async) begin
			v[0] = 1'b0;
			n = 4'h1;
		end
		for (i = 0; i < 8; i++) begin
			if (4'(i) < len) begin
				v[n + 4'(i)] = d[i];
			end
		end
		n = n + len;
		if (m[MODE_PEN]) begin
			v[n] = parity(d, len, m[MODE_PEVEN]);
			n = n + 4'h1;
		end
		if (is_async) begin
			n = n + (m[MODE_STOP2] ? 4'h2 : 4'h1);
		end
		return {n, v};
	endfunction

	// newest bit sits in h[15]; skip drops that many newest bits
	function automatic logic [7:0] extract(input logic [15:0] h, input logic [3:0] len,
			input logic [3:0] skip);
		logic [15:0] t;
		t = h >> (5'h10 - {1'b0, len} - {1'b0, skip});
		return t[7:0] & len_mask(len);
	endfunction
endpackage

// >>> usst_station.sv
// usst_station: remote serial station on the far side of the transceiver
// assumes clk_i is the 10 MHz system clock; one bit clock of clk/8 serves both directions
`timescale 1ns/1ns
module usst_station (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tx_i,
	output logic      bit_clock_o,
	output logic      rx_o
);
	logic [2:0] cnt_q;
	event       fall;

	initial rx_o = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// line clocks of this kind run free, frames or not
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == 3'h3) begin
				-> fall;
			end
		end
	end
	assign bit_clock_o = ~cnt_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// change data on the falling edge so it is stable at the rising one
	task automatic send(input logic [15:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(fall);
			rx_o <= b[i];
		end
		@(fall);
		rx_o <= 1'b1;
	endtask

	// sample mid-bit, away from the rising edge where the line changes
	task automatic capture(output logic [15:0] b, input int n);
		int w;
		b = 16'hffff;
		w = 0;
		do begin
			@(fall);
			w++;
		end while (tx_i !== 1'b0 && w < 100);
		b[0] = tx_i;
		for (int i = 1; i < n; i++) begin
			@(fall);
			b[i] = tx_i;
		end
	endtask
endmodule

// >>> testbench.sv
// testbench: drives the transceiver over Avalon-MM, checks it against a queue model
// assumes usst_station gives the line clocks and the far end of the serial link
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] a_ctl = usst_pkg::ADDR_CTRL;
	localparam logic [7:0] a_dat = usst_pkg::ADDR_DATA;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        cts_n_i = 1'b0;
	logic        ext_sync = 1'b0;
	logic        bit_clock;
	logic        rx_line;
	logic        tx_o;
	logic        tx_ready_line_o;
	logic        tx_drained_o;
	logic        rx_char_avail_o;
	logic        sync_found_out_o;
	logic [7:0]  st;
	logic [7:0]  s;
	logic [15:0] fr;
	logic [7:0]  q[$];
	int          err_total = 0;
	int          comparisons = 0;

	always #50 clk_i = ~clk_i;

	usst_core i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'h1), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .cts_n_i(cts_n_i), .tx_bit_clock_i(bit_clock),
		.rx_bit_clock_i(bit_clock), .rx_i(rx_line), .ext_sync_in_i(ext_sync), .tx_o(tx_o),
		.tx_ready_line_o(tx_ready_line_o), .tx_drained_o(tx_drained_o),
		.rx_char_avail_o(rx_char_avail_o), .sync_found_out_o(sync_found_out_o));

	usst_station i_station (.clk_i(clk_i), .rst_i(rst_i), .tx_i(tx_o), .bit_clock_o(bit_clock),
		.rx_o(rx_line));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
			output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		rd = avs_readdata_o[7:0];
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 20) begin
			chk("waitrequest", 0, 1);
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] dummy;
		bus(1'b1, a, v, dummy);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		bus(1'b0, a, 8'h00, v);
	endtask

	// 0: char ready, 1: sync found, 2: ready line
	task automatic await(input int sel);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (n < 400 && (sel == 0 ? rx_char_avail_o : sel == 1 ? sync_found_out_o
			: tx_ready_line_o) !== 1'b1);
		if (n >= 400) begin
			chk("wait", 0, 1);
			conclude();
		end
	endtask

	// async x1, 8 bits, even parity, one stop; lsb first
	function automatic logic [15:0] frame_of(input logic [7:0] v, input logic par,
			input logic stp);
		return {5'h1f, stp, par, v, 1'b0};
	endfunction

	// kind 0 clean, 1 bad parity, 2 low stop bit
	task automatic rx_frame(input int kind);
		logic [7:0] v;
		v = 8'($urandom);
		q.push_back(v);
		i_station.send(frame_of(v, (kind == 1) ? ~^v : ^v, kind != 2), 11);
		await(0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6ff8));
		repeat (3) @(posedge clk_i);
		chk("tx idle", tx_o, 1);
		chk("drained", tx_drained_o, 1);
		chk("ready line", tx_ready_line_o, 0);
		rst_i <= 1'b0;
		wr(a_ctl, 8'h3d);
		wr(a_ctl, 8'h15);
		@(posedge clk_i);
		chk("ready line", tx_ready_line_o, 1);
		cts_n_i <= 1'b1;
		rd(a_ctl, st);
		chk("buffer writable", st[0], 1);
		chk("ready line", tx_ready_line_o, 0);
		cts_n_i <= 1'b0;
		$display("done setup");
		q.push_back(8'($urandom));
		q.push_back(8'($urandom));
		fork
			begin
				i_station.capture(fr, 11);
				chk("frame", fr, frame_of(q[0], ^q[0], 1'b1));
				i_station.capture(fr, 11);
				chk("frame", fr, frame_of(q[1], ^q[1], 1'b1));
			end
			begin
				wr(a_dat, q[0]);
				@(posedge clk_i);
				chk("drained", tx_drained_o, 0);
				await(2);
				wr(a_dat, q[1]);
				await(2);
				wr(a_ctl, 8'h14);
			end
		join
		repeat (20) @(posedge clk_i);
		chk("tx mark", tx_o, 1);
		chk("ready line", tx_ready_line_o, 0);
		chk("drained", tx_drained_o, 1);
		q.delete();
		wr(a_ctl, 8'h0d);
		repeat (2) @(posedge clk_i);
		chk("break", tx_o, 0);
		wr(a_ctl, 8'h04);
		$display("done transmit");
		for (int k = 0; k < 3; k++) begin
			rx_frame(k);
			rd(a_ctl, st);
			chk("status", {st[5], st[3], st[1]}, {k == 2, k == 1, 1'b1});
			rd(a_dat, st);
			chk("rx data", st, q.pop_front());
			@(posedge clk_i);
			chk("char avail", rx_char_avail_o, 0);
			wr(a_ctl, 8'h14);
		end
		rx_frame(0);
		rx_frame(0);
		rd(a_ctl, st);
		chk("status", {st[5], st[4], st[1]}, 3'b011);
		wr(a_ctl, 8'h00);
		@(posedge clk_i);
		chk("char avail", rx_char_avail_o, 0);
		i_station.send(frame_of(8'h5a, 1'b0, 1'b1), 11);
		repeat (8) @(posedge clk_i);
		rd(a_ctl, st);
		chk("status", {st[4], st[1]}, 2'b00);
		q.delete();
		$display("done receive");
		// top bit clear so the idle ones never match the sync character
		s = 8'($urandom) & 8'h7f;
		wr(a_ctl, 8'h40);
		wr(a_ctl, 8'h8c);
		wr(a_ctl, s);
		wr(a_ctl, 8'h85);
		repeat (20) @(posedge clk_i);
		chk("sync found", sync_found_out_o, 0);
		chk("sync tx mark", tx_o, 1);
		i_station.send({s, s}, 16);
		await(1);
		rd(a_ctl, st);
		chk("status found", st[6], 1);
		chk("sync avail", st[1], 1);
		wr(a_ctl, 8'h40);
		wr(a_ctl, 8'hcc);
		wr(a_ctl, s);
		wr(a_ctl, 8'h85);
		i_station.send({s, s}, 16);
		chk("ext no compare", sync_found_out_o, 0);
		// held over two rx clock edges, longer than one rx cycle
		ext_sync <= 1'b1;
		await(1);
		ext_sync <= 1'b0;
		rd(a_ctl, st);
		chk("ext found", st[6], 1);
		$display("done sync");
		conclude();
	end
endmodule
